// ===== rtl/ocpw_top.sv
// Output compare pair: two compare channels driving two output levels,
// with an APB register slave.
// Assumes the free-running timer shares pclk and gives count, peak,
// direction and a one-cycle tick for each new count value.
//
// Contract
// - Up 1-change: match 0 toggles output 0.
// - Up 1-change: match 1 toggles output 1.
// - Up modes: compare above peak never matches.
// - Up 2-change: either match toggles output 1.
// - Only channel 1 offers 2-change mode.
// - Matches set their match flags, except up/down matches at zero or at peak.
// - Zero transfer loads buffer at count zero.
// - Peak transfer loads at peak, compares same cycle.
// - Active-high: up match high, down low.
// - Active-high: zero holds high, full holds low.
// - Active-low: levels inverted from active-high.
// - Channel 1 up/down behaves like channel 0.
// - Up/down: loading zero forces active immediately.
// - Up/down: compare at/above peak, except full, changes nothing.
// - Up/down: match at peak changes nothing.
// - Mode decoded from timer, change and pair bits.
// - Outputs change only while channel runs.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ocpw_consts.svh"

module ocpw_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] timer_count,
	input wire logic [15:0] cycle_peak_value,
	input wire logic timer_down,
	input wire logic timer_tick,
	input wire logic timer_mode_0,
	input wire logic timer_mode_1,
	output logic compare_out_0,
	output logic compare_out_1,
	output logic match_flag_0,
	output logic match_flag_1
);

	// ****************************************************************
	// Mode decoding
	// ****************************************************************
	// Unlisted combinations decode to a mode that freezes the output.
	function automatic ocpw_pkg::ocpw_mode_t mode_dec(
		input logic ch1,
		input logic tmode,
		input logic change_mode_select,
		input logic [1:0] pair);
		logic sel;
		sel = ch1 ? pair[1] : pair[0];
		if (!tmode)
		begin
			if (ch1 && change_mode_select)
				return (pair == `OCPW_PAIR_2CHG) ? ocpw_pkg::OCPW_UP2
					: ocpw_pkg::OCPW_BAD;
			return ocpw_pkg::OCPW_UP1;
		end
		if (!sel)
			return ocpw_pkg::OCPW_BAD;
		return change_mode_select ? ocpw_pkg::OCPW_UDL : ocpw_pkg::OCPW_UDH;
	endfunction : mode_dec

	// ****************************************************************
	// State
	// ****************************************************************
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [15:0] cmp_r [2];
	logic [15:0] cmp_nxt [2];
	logic [15:0] buf_r [2];
	logic [15:0] buf_nxt [2];
	logic [15:0] eff [2];
	logic [1:0] out_r, out_nxt;
	logic [1:0] flag_r, flag_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [1:0] run, bufen, xpeak, hit, xfer, wr_cmp, set, clr;
	ocpw_pkg::ocpw_mode_t mode [2];
	logic wr, setup, change_mode_select, act;
	logic [1:0] pair;

	assign change_mode_select = ctrl_r[`OCPW_CHANGE_MODE_SELECT_BIT];
	assign pair = ctrl_r[`OCPW_MODE_LSB+1:`OCPW_MODE_LSB];
	assign run = {ctrl_r[`OCPW_RUN1_BIT], ctrl_r[`OCPW_RUN0_BIT]};
	assign bufen = {ctrl_r[`OCPW_BUFEN1_BIT], ctrl_r[`OCPW_BUFEN0_BIT]};
	assign xpeak = {ctrl_r[`OCPW_XPEAK1_BIT], ctrl_r[`OCPW_XPEAK0_BIT]};
	assign mode[0] = mode_dec(1'b0, timer_mode_0, change_mode_select, pair);
	assign mode[1] = mode_dec(1'b1, timer_mode_1, change_mode_select, pair);
	assign wr = psel && penable && pwrite;
	assign setup = psel && !penable;
	assign wr_cmp[0] = wr && (paddr == `OCPW_CMP0_OFS);
	assign wr_cmp[1] = wr && (paddr == `OCPW_CMP1_OFS);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		out_nxt = out_r;
		flag_nxt = flag_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		hit = 2'b00;
		xfer = 2'b00;
		set = 2'b00;
		clr = 2'b00;
		act = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			// The new value is compared in the transfer cycle itself.
			xfer[i] = timer_tick && bufen[i] && (xpeak[i]
				? (timer_count == cycle_peak_value)
				: (timer_count == `OCPW_CMP_ZERO));
			eff[i] = xfer[i] ? buf_r[i] : cmp_r[i];
			// A count never exceeds the peak, but a bad peak must not
			// let a large compare value through.
			hit[i] = timer_tick && (timer_count == eff[i])
				&& (eff[i] <= cycle_peak_value);
			cmp_nxt[i] = xfer[i] ? buf_r[i] : cmp_r[i];
			buf_nxt[i] = buf_r[i];
			if (wr_cmp[i] && bufen[i])
				buf_nxt[i] = pwdata[15:0];
			else if (wr_cmp[i])
				cmp_nxt[i] = pwdata[15:0];
		end
		for (int i = 0; i < 2; i++)
		begin
			act = (mode[i] == ocpw_pkg::OCPW_UDH);
			if (run[i])
			begin
				unique case (mode[i])
					ocpw_pkg::OCPW_UP1:
					begin
						out_nxt[i] = out_r[i] ^ hit[i];
						set[i] = hit[i];
					end
					ocpw_pkg::OCPW_UP2:
					begin
						out_nxt[i] = out_r[i] ^ (hit[0] || hit[1]);
						set[i] = hit[i];
					end
					ocpw_pkg::OCPW_UDH, ocpw_pkg::OCPW_UDL:
					begin
						// Leaving the all-active value drops the output to
						// inactive at once, not at the next match.
						if (cmp_r[i] == `OCPW_CMP_ZERO
							&& cmp_nxt[i] != `OCPW_CMP_ZERO)
							out_nxt[i] = !act;
						else if (eff[i] == `OCPW_CMP_ZERO)
							out_nxt[i] = act;
						else if (eff[i] == `OCPW_CMP_FULL)
							out_nxt[i] = !act;
						else if (hit[i] && (eff[i] < cycle_peak_value)
							&& (timer_count != cycle_peak_value))
						begin
							out_nxt[i] = timer_down ? !act : act;
							set[i] = 1'b1;
						end
					end
					ocpw_pkg::OCPW_BAD:
						out_nxt[i] = out_r[i];
				endcase
			end
		end
		if (wr && (paddr == `OCPW_CTRL_OFS))
			ctrl_nxt = pwdata & `OCPW_CTRL_MASK;
		if (wr && (paddr == `OCPW_STAT_OFS))
			clr = {pwdata[`OCPW_FLAG1_BIT], pwdata[`OCPW_FLAG0_BIT]};
		// A match in the clearing cycle survives the clear.
		flag_nxt = (flag_r & ~clr) | set;
		if (setup)
		begin
			prdata_nxt = 32'h00000000;
			pslverr_nxt = 1'b0;
			unique case (paddr)
				`OCPW_CTRL_OFS: prdata_nxt = ctrl_r;
				`OCPW_STAT_OFS:
				begin
					prdata_nxt[`OCPW_FLAG0_BIT] = flag_r[0];
					prdata_nxt[`OCPW_FLAG1_BIT] = flag_r[1];
					prdata_nxt[`OCPW_OUT0_BIT] = out_r[0];
					prdata_nxt[`OCPW_OUT1_BIT] = out_r[1];
				end
				`OCPW_CMP0_OFS: prdata_nxt[15:0] = cmp_r[0];
				`OCPW_CMP1_OFS: prdata_nxt[15:0] = cmp_r[1];
				default: pslverr_nxt = 1'b1;
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= `OCPW_CTRL_RST;
			cmp_r[0] <= `OCPW_CMP_RST;
			cmp_r[1] <= `OCPW_CMP_RST;
			buf_r[0] <= `OCPW_CMP_RST;
			buf_r[1] <= `OCPW_CMP_RST;
			out_r <= 2'h0;
			flag_r <= 2'h0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			cmp_r[0] <= cmp_nxt[0];
			cmp_r[1] <= cmp_nxt[1];
			buf_r[0] <= buf_nxt[0];
			buf_r[1] <= buf_nxt[1];
			out_r <= out_nxt;
			flag_r <= flag_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Zero wait states: read data is latched in the setup cycle.
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign compare_out_0 = out_r[0];
	assign compare_out_1 = out_r[1];
	assign match_flag_0 = flag_r[0];
	assign match_flag_1 = flag_r[1];

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	up1_toggle_a: assert property (
		run[0] && mode[0] == ocpw_pkg::OCPW_UP1 && hit[0]
		|=> compare_out_0 != $past(compare_out_0))
		else $error("Output 0 did not toggle on match.");

	up1_hold_a: assert property (
		run[1] && mode[1] == ocpw_pkg::OCPW_UP1 && !hit[1]
		|=> $stable(compare_out_1))
		else $error("Output 1 changed without a match.");

	up2_toggle_a: assert property (
		run[1] && mode[1] == ocpw_pkg::OCPW_UP2 && (hit[0] || hit[1])
		|=> compare_out_1 != $past(compare_out_1))
		else $error("Output 1 missed a 2-change toggle.");

	flag_set_a: assert property (
		run[0] && mode[0] == ocpw_pkg::OCPW_UP1 && hit[0]
		|=> match_flag_0)
		else $error("Match flag 0 not set by a match.");

	zero_xfer_a: assert property (
		xfer[0] && !xpeak[0] && !wr_cmp[0]
		|=> cmp_r[0] == $past(buf_r[0]) && $past(timer_count) == 16'h0000)
		else $error("Zero transfer did not load channel 0.");

	udh_zero_a: assert property (
		run[0] && mode[0] == ocpw_pkg::OCPW_UDH && eff[0] == 16'h0000
		&& !wr_cmp[0]
		|=> compare_out_0)
		else $error("Zero compare did not force active high.");

	udl_full_a: assert property (
		run[1] && mode[1] == ocpw_pkg::OCPW_UDL && eff[1] == 16'hFFFF
		|=> compare_out_1)
		else $error("Full compare did not hold active-low inactive.");

	ud_peak_a: assert property (
		run[0] && mode[0] == ocpw_pkg::OCPW_UDH
		&& timer_count == cycle_peak_value && eff[0] != 16'h0000
		&& eff[0] != 16'hFFFF
		|=> $stable(compare_out_0) && !$rose(match_flag_0))
		else $error("Peak match changed output 0 or its flag.");

	udh_dir_a: assert property (
		run[1] && mode[1] == ocpw_pkg::OCPW_UDH && hit[1]
		&& eff[1] != 16'h0000 && eff[1] < cycle_peak_value
		&& timer_count != cycle_peak_value
		|=> compare_out_1 == !$past(timer_down))
		else $error("Active-high output 1 took the wrong level.");

	run_gate_a: assert property (
		!run[0] |=> $stable(compare_out_0))
		else $error("Output 0 changed while its channel was stopped.");

	up1_cover: cover property (
		mode[0] == ocpw_pkg::OCPW_UP1 && run[0] && hit[0]);
	up2_cover: cover property (
		mode[1] == ocpw_pkg::OCPW_UP2 && run[1] && hit[0] ##[1:50] hit[1]);
	udl_cover: cover property (
		mode[1] == ocpw_pkg::OCPW_UDL && $fell(compare_out_1));
	peak_xfer_cover: cover property (xfer[0] && xpeak[0] && hit[0]);

endmodule : ocpw_top

`default_nettype wire

// ===== shared/ocpw_consts.svh
// Register offsets, field positions, reset values and special compare
// values of the output compare pair.
// Assumes a 16-bit timer count and an 8-bit APB byte address.
`ifndef OCPW_CONSTS_SVH
`define OCPW_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OCPW_CTRL_OFS 8'h00
`define OCPW_STAT_OFS 8'h04
`define OCPW_CMP0_OFS 8'h08
`define OCPW_CMP1_OFS 8'h0C

// ****************************************************************
// Control register fields
// ****************************************************************
`define OCPW_RUN0_BIT 0
`define OCPW_RUN1_BIT 1
`define OCPW_CHANGE_MODE_SELECT_BIT 2
`define OCPW_MODE_LSB 4
`define OCPW_BUFEN0_BIT 8
`define OCPW_BUFEN1_BIT 9
`define OCPW_XPEAK0_BIT 10
`define OCPW_XPEAK1_BIT 11
`define OCPW_CTRL_MASK 32'h00000F37
`define OCPW_CTRL_RST 32'h00000000

// ****************************************************************
// Status register fields
// ****************************************************************
`define OCPW_FLAG0_BIT 0
`define OCPW_FLAG1_BIT 1
`define OCPW_OUT0_BIT 4
`define OCPW_OUT1_BIT 5

// ****************************************************************
// Compare values
// ****************************************************************
`define OCPW_CMP_RST 16'h0000
`define OCPW_CMP_ZERO 16'h0000
`define OCPW_CMP_FULL 16'hFFFF
`define OCPW_PAIR_2CHG 2'h0

`endif

// ===== shared/ocpw_pkg.sv
// Types shared by the output compare pair.
// Assumes nothing of its surroundings.
`default_nettype none

package ocpw_pkg;

	// ****************************************************************
	// Channel operating modes
	// ****************************************************************
	typedef enum logic [4:0] {
		OCPW_UP1 = 5'h01,
		OCPW_UP2 = 5'h02,
		OCPW_UDH = 5'h04,
		OCPW_UDL = 5'h08,
		OCPW_BAD = 5'h10
	} ocpw_mode_t;

endpackage : ocpw_pkg

`default_nettype wire

// ===== test/ocpw_bench.sv
// Self-checking bench of the output compare pair.
// Assumes the timer model and the design share pclk.
`timescale 1ns/10ps
`default_nettype none
`include "ocpw_consts.svh"

module ocpw_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] cnt;
	logic dn;
	logic tk;
	logic run = 1'b0;
	logic tm0 = 1'b0;
	logic tm1 = 1'b0;
	logic o0;
	logic o1;
	logic f0;
	logic f1;
	logic [31:0] rd;
	logic er;
	int failures = 0;
	int cmp_count = 0;

	always #10 pclk = ~pclk;

	ocpw_timer_model u_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.updown(tm0 | tm1),
		.peak(16'h0009),
		.count(cnt),
		.down(dn),
		.tick(tk)
	);

	ocpw_top u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.timer_count(cnt),
		.cycle_peak_value(16'h0009),
		.timer_down(dn),
		.timer_tick(tk),
		.timer_mode_0(tm0),
		.timer_mode_1(tm1),
		.compare_out_0(o0),
		.compare_out_1(o1),
		.match_flag_0(f0),
		.match_flag_1(f1)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Only the watchdog ends a wait for pready; an idle edge follows each
	// transfer so that back-to-back calls never drive psel twice at once.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h00000000);
		chk(n, e, rd);
	endtask : rchk

	// Two spare edges let the last tick reach the outputs.
	task tmr(input int n);
		run <= 1'b1;
		repeat (n) @(posedge pclk);
		run <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : tmr

	task rst();
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : rst

	task wrap_up();
		$display("Compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_reset();
		rchk(`OCPW_CTRL_OFS, 32'h00000000, "ctrl");
		rchk(`OCPW_STAT_OFS, 32'h00000000, "stat");
		apb(1'b0, 8'h10, 32'h00000000);
		chk("slverr", 32'h00000001, {31'h0, er});
	endtask : t_reset

	task t_up1();
		rst();
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000003);
		apb(1'b1, `OCPW_CMP1_OFS, 32'h00000014);
		apb(1'b1, `OCPW_CTRL_OFS, 32'h00000003);
		tmr(10);
		chk("out0", 32'h00000001, {31'h0, o0});
		chk("flag0", 32'h00000001, {31'h0, f0});
		rchk(`OCPW_STAT_OFS, 32'h00000011, "up1 a");
		apb(1'b1, `OCPW_CMP1_OFS, 32'h00000005);
		apb(1'b1, `OCPW_CTRL_OFS, 32'h00000002);
		tmr(10);
		rchk(`OCPW_STAT_OFS, 32'h00000033, "up1 b");
		apb(1'b1, `OCPW_STAT_OFS, 32'h00000001);
		chk("flags", 32'h00000002, {30'h0, f1, f0});
		rchk(`OCPW_STAT_OFS, 32'h00000032, "up1 c");
	endtask : t_up1

	task t_up2();
		rst();
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000002);
		apb(1'b1, `OCPW_CMP1_OFS, 32'h00000006);
		apb(1'b1, `OCPW_CTRL_OFS, 32'h00000007);
		tmr(5);
		rchk(`OCPW_STAT_OFS, 32'h00000031, "up2 a");
		tmr(5);
		rchk(`OCPW_STAT_OFS, 32'h00000013, "up2 b");
	endtask : t_up2

	task t_buf();
		rst();
		apb(1'b1, `OCPW_CTRL_OFS, 32'h00000101);
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000003);
		rchk(`OCPW_CMP0_OFS, 32'h00000000, "buf held");
		tmr(10);
		rchk(`OCPW_CMP0_OFS, 32'h00000003, "zero xfer");
		apb(1'b1, `OCPW_CTRL_OFS, 32'h00000501);
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000009);
		tmr(9);
		chk("peak out0", 32'h00000000, {31'h0, o0});
		rchk(`OCPW_CMP0_OFS, 32'h00000009, "peak xfer");
	endtask : t_buf

	task t_udh();
		rst();
		tm0 <= 1'b1;
		tm1 <= 1'b1;
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000004);
		apb(1'b1, `OCPW_CMP1_OFS, 32'h00000006);
		apb(1'b1, `OCPW_CTRL_OFS, 32'h00000033);
		tmr(9);
		rchk(`OCPW_STAT_OFS, 32'h00000033, "udh up");
		tmr(9);
		rchk(`OCPW_STAT_OFS, 32'h00000003, "udh down");
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000000);
		repeat (2) @(posedge pclk);
		chk("udh zero", 32'h00000001, {31'h0, o0});
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000009);
		repeat (2) @(posedge pclk);
		chk("udh back", 32'h00000000, {31'h0, o0});
		apb(1'b1, `OCPW_CMP0_OFS, 32'h0000FFFF);
		repeat (2) @(posedge pclk);
		chk("udh full", 32'h00000000, {31'h0, o0});
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000009);
		tmr(18);
		chk("udh peak", 32'h00000000, {31'h0, o0});
	endtask : t_udh

	task t_udl();
		rst();
		tm0 <= 1'b1;
		tm1 <= 1'b1;
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000004);
		apb(1'b1, `OCPW_CMP1_OFS, 32'h0000FFFF);
		apb(1'b1, `OCPW_CTRL_OFS, 32'h00000037);
		@(posedge pclk);
		chk("udl full", 32'h00000001, {31'h0, o1});
		apb(1'b1, `OCPW_CMP1_OFS, 32'h00000006);
		// The buffers get the running values, so the zero transfer at
		// the end of the down slope keeps them.
		apb(1'b1, `OCPW_CTRL_OFS, 32'h00000337);
		apb(1'b1, `OCPW_CMP0_OFS, 32'h00000004);
		apb(1'b1, `OCPW_CMP1_OFS, 32'h00000006);
		tmr(9);
		rchk(`OCPW_STAT_OFS, 32'h00000003, "udl up");
		tmr(9);
		rchk(`OCPW_STAT_OFS, 32'h00000033, "udl down");
	endtask : t_udl

	initial
	begin
		rst();
		t_reset();
		t_up1();
		t_up2();
		t_buf();
		t_udh();
		t_udl();
		wrap_up();
	end

	// The whole run needs well under a thousand cycles.
	initial
	begin
		#200000;
		failures++;
		wrap_up();
	end
endmodule : ocpw_bench

`default_nettype wire

// ===== test/ocpw_timer_model.sv
// Free-running timer model feeding the output compare pair.
// Assumes the bench starts and stops it through run, on pclk.
`timescale 1ns/10ps
`default_nettype none

module ocpw_timer_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic updown,
	input wire logic [15:0] peak,
	output logic [15:0] count,
	output logic down,
	output logic tick
);
	logic go_dn;
	logic [15:0] nxt;

	// Turning at the peak and at zero keeps each period exact.
	always_comb
	begin
		go_dn = updown && ((down && count != 16'h0000) || count == peak);
		nxt = go_dn ? count - 16'h0001 : count + 16'h0001;
		if (!updown && count == peak)
			nxt = 16'h0000;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= 16'h0000;
			down <= 1'b0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= run;
			if (run)
			begin
				count <= nxt;
				down <= go_dn;
			end
		end
	end
endmodule : ocpw_timer_model

`default_nettype wire
